// ---- rtl/ssf_pkg.sv ----
package ssf_pkg;

  // ************************************************
  // command codes
  // ************************************************
  localparam logic [7:0] OP_CMP_BUF1   = 8'h60;
  localparam logic [7:0] OP_CMP_BUF2   = 8'h61;
  localparam logic [7:0] OP_REWR_BUF1  = 8'h58;
  localparam logic [7:0] OP_REWR_BUF2  = 8'h59;
  localparam logic [7:0] OP_STATUS     = 8'hd7;
  localparam logic [7:0] OP_SLEEP      = 8'hb9;
  localparam logic [7:0] OP_WAKE       = 8'hab;
  localparam logic [7:0] OP_NONE       = 8'h00;

  // ************************************************
  // frame lengths and address layout
  // ************************************************
  localparam logic [5:0] OPCODE_BITS   = 6'h08;
  localparam logic [5:0] ADDR_CMD_BITS = 6'h20;
  localparam logic [5:0] STAT_CMD_BITS = 6'h10;
  localparam int         PAGE_BITS     = 13;
  localparam int         STD_PAGE_LSB  = 10;
  localparam int         BIN_PAGE_LSB  = 9;

  // ************************************************
  // status byte fields
  // ************************************************
  localparam int         ST_READY_BIT  = 7;
  localparam int         ST_CMP_BIT    = 6;
  localparam int         ST_PROT_BIT   = 1;
  localparam int         ST_PSIZE_BIT  = 0;

  // ************************************************
  // timing, clock period 10 ns
  // ************************************************
  localparam int         CLK_PERIOD_NS    = 10;
  localparam int         COMPARE_TIME_NS  = 1000;
  localparam int         REWRITE_TIME_NS  = 20000;
  localparam int         SLEEP_ENTRY_NS   = 3000;
  localparam int         WAKE_TIME_NS     = 30000;
  localparam int         CS_GAP_NS        = 50;
  localparam int         COMPARE_CYC      = COMPARE_TIME_NS / CLK_PERIOD_NS;
  localparam int         REWRITE_CYC      = REWRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int         SLEEP_ENTRY_CYC  = SLEEP_ENTRY_NS / CLK_PERIOD_NS;
  localparam int         WAKE_CYC         = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         CS_GAP_CYC       = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         SCK_HALF_CYC     = 8;

  // ************************************************
  // host register map
  // ************************************************
  localparam logic [3:0] REG_CMD       = 4'h0;
  localparam logic [3:0] REG_PAGE      = 4'h4;
  localparam logic [3:0] REG_STAT      = 4'h8;
  localparam logic [3:0] REG_CFG       = 4'hc;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_COMP  = 6'h02,
    ST_REWR  = 6'h04,
    ST_ENTER = 6'h08,
    ST_SLEEP = 6'h10,
    ST_WAKE  = 6'h20
  } ssf_dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'h1,
    H_SHIFT = 3'h2,
    H_GAP   = 3'h4
  } ssf_host_state_t;

endpackage

// ---- rtl/ssf_link_if.sv ----
`timescale 1ns/1ns
interface ssf_link_if;
  logic csN;
  logic sck;
  logic si;
  logic soOut;
  logic soOeN;
  logic soWire;

  // released line reads high
  assign soWire = soOeN ? 1'b1 : soOut;

  modport dev  (input csN, input sck, input si, output soOut, output soOeN);
  modport host (output csN, output sck, output si, input soWire);
endinterface

// ---- rtl/ssf_flash_dev.sv ----
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
// Operation
// - codes 60h/61h compare buffer 1/2
// - 528 mode: page at address bits 22:10
// - 512 mode: page at address bits 21:9
// - compare starts when chip select rises
// - busy during compare, result into bit6
// - bit6 zero match, one mismatch
// - codes 58h/59h rewrite, same address layout
// - rewrite self-timed, busy throughout
// - host rewrites each page within 20000 ops
// - D7h reads status, output next clock
// - status shifted msb first, eight clocks
// - status repeats with fresh contents
// - bit7 one ready, zero busy
// - busy for all internal array operations
// - bit1 shows sector protection enabled
// - bit0 one for 512-byte pages
// - B9h then chip select rise sleeps
// - asleep, ignore all but resume
// - ABh then chip select rise wakes
// - host keeps chip select high during wake
// - power-up lands in standby
// - chip select high releases serial out
module ssf_flash_dev
  import ssf_pkg::*;
#(
  parameter int         COMPARE_CYCLES = COMPARE_CYC,
  parameter int         REWRITE_CYCLES = REWRITE_CYC,
  parameter int         ENTRY_CYCLES   = SLEEP_ENTRY_CYC,
  parameter int         WAKE_CYCLES    = WAKE_CYC,
  // arbitrary value
  parameter logic [3:0] DENSITY_CODE   = 4'h6
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  ssf_link_if.dev          link,
  input  wire logic        cmpMismatch,
  input  wire logic        protectOn,
  input  wire logic        binaryPage,
  input  wire logic        extBusy,
  output logic [12:0]      pageIndex,
  output logic             bufSel,
  output logic             cmpStart,
  output logic             rewriteStart,
  output logic             asleep,
  output logic             busyOut
);

  // ************************************************
  // pin synchronisers and edges
  // ************************************************
  logic [1:0]     csSync;
  logic [1:0]     sckSync;
  logic [1:0]     siSync;
  logic           csPrev;
  logic           sckPrev;
  logic           sckRise;
  logic           sckFall;
  logic           csRise;
  logic           selected;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      csSync  <= 2'h3;
      sckSync <= 2'h0;
      siSync  <= 2'h0;
      csPrev  <= 1'b1;
      sckPrev <= 1'b0;
    end else begin
      csSync  <= {csSync[0], link.csN};
      sckSync <= {sckSync[0], link.sck};
      siSync  <= {siSync[0], link.si};
      csPrev  <= csSync[1];
      sckPrev <= sckSync[1];
    end
  end

  assign selected = ~csSync[1];
  assign sckRise  = selected & sckSync[1] & ~sckPrev;
  assign sckFall  = selected & ~sckSync[1] & sckPrev;
  assign csRise   = csSync[1] & ~csPrev;

  // ************************************************
  // command and address shifter
  // ************************************************
  logic [31:0]    inShift;
  logic [5:0]     inCnt;
  logic [7:0]     opReg;
  logic [23:0]    addrBytes;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      inShift <= 32'h0;
      inCnt   <= 6'h0;
      opReg   <= OP_NONE;
    end else if (csPrev) begin
      if (!selected) begin
        inCnt <= 6'h0;
        opReg <= OP_NONE;
      end
    end else if (sckRise) begin
      inShift <= {inShift[30:0], siSync[1]};
      if (inCnt != 6'h3f) begin
        inCnt <= inCnt + 6'h1;
      end
      if (inCnt == OPCODE_BITS - 6'h1) begin
        opReg <= {inShift[6:0], siSync[1]};
      end
    end
  end

  assign addrBytes = inShift[23:0];

  // ************************************************
  // control state machine
  // ************************************************
  ssf_dev_state_t state;
  logic [31:0]    tmr;
  logic           cmpResult;
  logic           frameAddr;
  logic           frameOp;

  assign frameAddr = csRise && inCnt == ADDR_CMD_BITS;
  assign frameOp   = csRise && inCnt == OPCODE_BITS;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state        <= ST_IDLE;
      tmr          <= 32'h0;
      cmpResult    <= 1'b0;
      pageIndex    <= 13'h0;
      bufSel       <= 1'b0;
      cmpStart     <= 1'b0;
      rewriteStart <= 1'b0;
      asleep       <= 1'b0;
    end else begin
      cmpStart     <= 1'b0;
      rewriteStart <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (frameAddr && !extBusy) begin
            if (binaryPage) begin
              pageIndex <= addrBytes[BIN_PAGE_LSB +: PAGE_BITS];
            end else begin
              pageIndex <= addrBytes[STD_PAGE_LSB +: PAGE_BITS];
            end
            bufSel <= opReg[0];
            if (opReg == OP_CMP_BUF1 || opReg == OP_CMP_BUF2) begin
              state    <= ST_COMP;
              cmpStart <= 1'b1;
              tmr      <= 32'(COMPARE_CYCLES - 1);
            end else if (opReg == OP_REWR_BUF1 || opReg == OP_REWR_BUF2) begin
              state        <= ST_REWR;
              rewriteStart <= 1'b1;
              tmr          <= 32'(REWRITE_CYCLES - 1);
            end
          end else if (frameOp && opReg == OP_SLEEP && !extBusy) begin
            state <= ST_ENTER;
            tmr   <= 32'(ENTRY_CYCLES - 1);
          end
        end
        ST_COMP: begin
          if (tmr == 32'h0) begin
            cmpResult <= cmpMismatch;
            state     <= ST_IDLE;
          end else begin
            tmr <= tmr - 32'h1;
          end
        end
        ST_REWR: begin
          if (tmr == 32'h0) begin
            state <= ST_IDLE;
          end else begin
            tmr <= tmr - 32'h1;
          end
        end
        ST_ENTER: begin
          if (tmr == 32'h0) begin
            state  <= ST_SLEEP;
            asleep <= 1'b1;
          end else begin
            tmr <= tmr - 32'h1;
          end
        end
        ST_SLEEP: begin
          if (frameOp && opReg == OP_WAKE) begin
            state <= ST_WAKE;
            tmr   <= 32'(WAKE_CYCLES - 1);
          end
        end
        ST_WAKE: begin
          if (tmr == 32'h0) begin
            state  <= ST_IDLE;
            asleep <= 1'b0;
          end else begin
            tmr <= tmr - 32'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // status byte and busy flag
  // ************************************************
  logic           ready;
  logic [7:0]     statusLive;

  // sleep entry and wake are not array work, so they leave ready set
  assign ready = !(state == ST_COMP || state == ST_REWR) && !extBusy;

  always_comb begin
    statusLive               = {2'h0, DENSITY_CODE, 2'h0};
    statusLive[ST_READY_BIT] = ready;
    statusLive[ST_CMP_BIT]   = cmpResult;
    statusLive[ST_PROT_BIT]  = protectOn;
    statusLive[ST_PSIZE_BIT] = binaryPage;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busyOut <= 1'b0;
    end else begin
      busyOut <= !ready;
    end
  end

  // ************************************************
  // serial output
  // ************************************************
  logic [7:0]     statHold;
  logic [2:0]     outIdx;
  logic           statRd;

  assign statRd = opReg == OP_STATUS && inCnt >= OPCODE_BITS && state != ST_SLEEP;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      link.soOut  <= 1'b1;
      link.soOeN  <= 1'b1;
      statHold    <= 8'h0;
      outIdx      <= 3'h0;
    end else if (!selected) begin
      link.soOeN <= 1'b1;
      outIdx     <= 3'h0;
    end else if (sckFall && statRd) begin
      link.soOeN <= 1'b0;
      outIdx     <= outIdx + 3'h1;
      if (outIdx == 3'h0) begin
        statHold   <= statusLive;
        link.soOut <= statusLive[7];
      end else begin
        link.soOut <= statHold[3'h7 - outIdx];
      end
    end
  end

endmodule

// ---- rtl/ssf_flash_host.sv ----
`timescale 1ns/1ns
module ssf_flash_host
  import ssf_pkg::*;
#(
  parameter int HALF_CYCLES = SCK_HALF_CYC,
  parameter int WAKE_CYCLES = WAKE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  ssf_link_if.host         link,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ************************************************
  // register slave
  // ************************************************
  logic [3:0]      awAddr;
  logic [31:0]     wData;
  logic            awHave;
  logic            wHave;
  logic            wStrb0;
  logic            awFire;
  logic            wFire;
  logic            arFire;
  logic            doWrite;
  logic [12:0]     pageReg;
  logic            binaryMode;
  logic [7:0]      rxByte;
  logic            launch;
  ssf_host_state_t hState;

  assign awFire  = s_axi_awvalid & s_axi_awready;
  assign wFire   = s_axi_wvalid & s_axi_wready;
  assign arFire  = s_axi_arvalid & s_axi_arready;
  assign doWrite = awHave & wHave & ~s_axi_bvalid;
  assign launch  = doWrite && awAddr == REG_CMD && wStrb0 && hState == H_IDLE;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      awHave        <= 1'b0;
      wHave         <= 1'b0;
      awAddr        <= 4'h0;
      wData         <= 32'h0;
      wStrb0        <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      pageReg       <= 13'h0;
      binaryMode    <= 1'b0;
    end else begin
      if (awFire) begin
        awAddr <= s_axi_awaddr;
      end
      if (wFire) begin
        wData  <= s_axi_wdata;
        wStrb0 <= s_axi_wstrb[0];
      end
      awHave        <= (awHave | awFire) & ~doWrite;
      wHave         <= (wHave | wFire) & ~doWrite;
      s_axi_awready <= ~((awHave | awFire) & ~doWrite);
      s_axi_wready  <= ~((wHave | wFire) & ~doWrite);
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        if (awAddr == REG_PAGE) begin
          pageReg <= wData[12:0];
        end else if (awAddr == REG_CFG) begin
          binaryMode <= wData[0];
        end else if (awAddr != REG_CMD) begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~(arFire | (s_axi_rvalid & ~s_axi_rready));
      if (arFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        if (s_axi_araddr == REG_PAGE) begin
          s_axi_rdata <= {19'h0, pageReg};
        end else if (s_axi_araddr == REG_STAT) begin
          s_axi_rdata <= {16'h0, rxByte, 7'h0, hState != H_IDLE};
        end else if (s_axi_araddr == REG_CFG) begin
          s_axi_rdata <= {31'h0, binaryMode};
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************
  // link sequencer, mode 0
  // ************************************************
  logic [1:0]      soSync;
  logic [31:0]     txShift;
  logic [5:0]      nBits;
  logic [5:0]      bitCnt;
  logic [31:0]     divCnt;
  logic [31:0]     gapCnt;
  logic [7:0]      opcode;
  logic            isAddrCmd;
  logic [23:0]     addrBytes;

  assign opcode    = wData[7:0];
  assign isAddrCmd = opcode == OP_CMP_BUF1 || opcode == OP_CMP_BUF2
                  || opcode == OP_REWR_BUF1 || opcode == OP_REWR_BUF2;
  // 528 mode: one free bit, page, ten free bits; 512 mode: two, page, nine
  assign addrBytes = binaryMode ? {2'h0, pageReg, 9'h0}
                                : {1'h0, pageReg, 10'h0};

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      soSync     <= 2'h3;
    end else begin
      soSync     <= {soSync[0], link.soWire};
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hState   <= H_IDLE;
      link.csN <= 1'b1;
      link.sck <= 1'b0;
      link.si  <= 1'b0;
      txShift  <= 32'h0;
      nBits    <= 6'h0;
      bitCnt   <= 6'h0;
      divCnt   <= 32'h0;
      gapCnt   <= 32'h0;
      rxByte   <= 8'h0;
    end else begin
      case (hState)
        H_IDLE: begin
          if (launch) begin
            hState   <= H_SHIFT;
            link.csN <= 1'b0;
            link.si  <= opcode[7];
            txShift  <= {opcode[6:0], isAddrCmd ? addrBytes : 24'h0, 1'b0};
            bitCnt   <= 6'h0;
            divCnt   <= 32'h0;
            if (isAddrCmd) begin
              nBits <= ADDR_CMD_BITS;
            end else if (opcode == OP_STATUS) begin
              nBits <= STAT_CMD_BITS;
            end else begin
              nBits <= OPCODE_BITS;
            end
          end
        end
        H_SHIFT: begin
          if (divCnt == 32'(HALF_CYCLES - 1)) begin
            divCnt <= 32'h0;
            if (!link.sck) begin
              link.sck <= 1'b1;
              rxByte   <= {rxByte[6:0], soSync[1]};
            end else begin
              link.sck <= 1'b0;
              link.si  <= txShift[31];
              txShift  <= {txShift[30:0], 1'b0};
              bitCnt   <= bitCnt + 6'h1;
              if (bitCnt == nBits - 6'h1) begin
                hState   <= H_GAP;
                link.csN <= 1'b1;
                gapCnt   <= (opcode == OP_WAKE) ? 32'(WAKE_CYCLES - 1)
                                                : 32'(CS_GAP_CYC - 1);
              end
            end
          end else begin
            divCnt <= divCnt + 32'h1;
          end
        end
        H_GAP: begin
          if (gapCnt == 32'h0) begin
            hState <= H_IDLE;
          end else begin
            gapCnt <= gapCnt - 32'h1;
          end
        end
        default: begin
          hState <= H_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- dv/ssf_link_properties.sv ----
`timescale 1ns/1ns
module ssf_link_properties
  import ssf_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  input wire logic soOut,
  input wire logic soOeN,
  input wire logic soWire
);
  logic [7:0] rxByte;
  logic [3:0] rxBits;
  logic       statFrame;
  logic       sckQ;
  logic       csQ;
  int         wakeCnt;

  // ****
  // frame tracking
  // ****
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rxByte <= '0;
      rxBits <= '0;
      statFrame <= 1'b0;
      sckQ <= 1'b0;
      csQ <= 1'b1;
      wakeCnt <= 0;
    end else begin
      sckQ <= sck;
      csQ <= csN;
      if (csN) begin
        rxBits <= '0;
        statFrame <= 1'b0;
      end else if (sck && !sckQ) begin
        rxByte <= {rxByte[6:0], si};
        if (rxBits != 4'hf) rxBits <= rxBits + 4'h1;
        if (rxBits == 4'h7 && {rxByte[6:0], si} == OP_STATUS) statFrame <= 1'b1;
      end
      if (csN && !csQ && rxBits == 4'h8 && rxByte == OP_WAKE) wakeCnt <= WAKE_CYCLES - 1;
      else if (wakeCnt != 0) wakeCnt <= wakeCnt - 1;
    end
  end

  // ****
  // link properties
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  release_on_cs_a: assert property (csN[*6] |-> soOeN)
    else $error("serial out still driven after chip select rose");
  drive_only_status_a: assert property (!csN && !soOeN |-> statFrame)
    else $error("serial out driven outside a status frame");
  shift_on_fall_a: assert property (!soOeN && $changed(soOut) |-> !sck)
    else $error("serial out changed while clock high");
  si_hold_a: assert property (sck && $past(sck) |-> $stable(si))
    else $error("serial in changed while clock high");
  sck_idle_a: assert property (csN |-> !sck)
    else $error("serial clock high outside a frame");
  half_period_a: assert property ($rose(sck) |-> sck[*8])
    else $error("serial clock high phase too short");
  cs_gap_a: assert property ($rose(csN) |-> csN[*5])
    else $error("chip select gap too short");
  wake_hold_a: assert property (wakeCnt != 0 |-> csN)
    else $error("chip select fell during wake time");
  line_release_a: assert property (soOeN |-> soWire)
    else $error("released serial out does not read high");
endmodule

// ---- dv/serial_flash_compare_status_sleep_tb.sv ----
`timescale 1ns/1ns
module serial_flash_compare_status_sleep_tb
  import ssf_pkg::*;
();
  localparam int         CMP_N = 12;
  localparam int         RW_N  = 20;
  localparam int         WK_N  = 10;
  // arbitrary value
  localparam logic [3:0] DENS  = 4'h9;

  logic        clk_sys, sys_rst, cmpMismatch, protectOn, binaryPage, extBusy;
  logic        bufSel, cmpStart, rewriteStart, asleep, busyOut;
  logic        capBuf, rwSeen, sckQ, lastMis, mis;
  logic [12:0] pageIndex, capPage, page;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, siBits, d;
  logic [7:0]  soBits, op;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  ops [4] = '{OP_CMP_BUF1, OP_CMP_BUF2, OP_REWR_BUF1, OP_REWR_BUF2};
  int          failCount, cmpCount, seed, starts, busyCnt, k, n0;

  ssf_link_if link ();
  ssf_flash_dev #(.COMPARE_CYCLES(CMP_N), .REWRITE_CYCLES(RW_N), .ENTRY_CYCLES(8),
    .WAKE_CYCLES(WK_N), .DENSITY_CODE(DENS)) u_ssf_flash_dev (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .link(link), .cmpMismatch(cmpMismatch), .protectOn(protectOn),
    .binaryPage(binaryPage), .extBusy(extBusy), .pageIndex(pageIndex), .bufSel(bufSel),
    .cmpStart(cmpStart), .rewriteStart(rewriteStart), .asleep(asleep), .busyOut(busyOut));
  ssf_flash_host #(.WAKE_CYCLES(14)) u_ssf_flash_host (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .link(link), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ssf_link_properties #(.WAKE_CYCLES(WK_N)) u_ssf_link_properties (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .csN(link.csN), .sck(link.sck), .si(link.si), .soOut(link.soOut),
    .soOeN(link.soOeN), .soWire(link.soWire));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ****
  // monitors and tasks
  // ****
  always @(posedge clk_sys) begin
    sckQ <= link.sck;
    if (cmpStart || rewriteStart) begin
      starts <= starts + 1;
      rwSeen <= rewriteStart;
      capPage <= pageIndex;
      capBuf <= bufSel;
      busyCnt <= 0;
    end else if (busyOut) busyCnt <= busyCnt + 1;
    if (!link.csN && link.sck && !sckQ) begin
      siBits <= {siBits[30:0], link.si};
      soBits <= {soBits[6:0], link.soWire};
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e) begin
      failCount++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_max(input string nm, input int lim, input int g);
    cmpCount++;
    if (g > lim) begin
      failCount++;
      $display("FAIL %s expected at most %0d seen %0d", nm, lim, g);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic link_cmd(input logic [7:0] c);
    do axi_rd(REG_STAT); while (d[0] !== 1'b0);
    axi_wr(REG_CMD, {24'h0, c});
    do axi_rd(REG_STAT); while (d[0] !== 1'b0);
  endtask

  function automatic logic [7:0] exp_stat(input logic rdy, input logic m);
    return {rdy, m, DENS, protectOn, binaryPage};
  endfunction

  task automatic check_status(input logic [7:0] e);
    link_cmd(OP_STATUS);
    axi_rd(REG_STAT);
    chk("status opcode", 32'(OP_STATUS), 32'(siBits[15:8]));
    chk("status wire", 32'(e), 32'(soBits));
    chk("status reg", 32'(e), 32'(d[15:8]));
  endtask

  task automatic wait_sleep(input logic v);
    k = 0;
    while (asleep !== v && k < 200) begin
      @(posedge clk_sys);
      k++;
    end
  endtask

  task automatic wrap_up;
    if (failCount == 0 && cmpCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    failCount++;
    wrap_up();
  end

  // ****
  // scenarios
  // ****
  initial begin
    seed = 4;
    sys_rst = 1'b1;
    {cmpMismatch, protectOn, binaryPage, extBusy, lastMis} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, starts, failCount, cmpCount} = '0;
    wstrb = 4'hf;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk("asleep at start", 0, 32'(asleep));
    check_status(exp_stat(1'b1, 1'b0));
    axi_rd(4'h6);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    axi_wr(REG_STAT, 32'h0);
    chk("read-only write resp", 32'(RESP_SLVERR), 32'(r));
    for (int i = 0; i < 8; i++) begin
      op = ops[i % 4];
      page = (i == 0) ? 13'h1fff : (i == 1) ? 13'h0 : 13'($random(seed));
      mis = 1'($random(seed));
      @(posedge clk_sys);
      binaryPage <= i[2];
      protectOn <= 1'($random(seed));
      cmpMismatch <= mis;
      axi_wr(REG_CFG, {31'h0, i[2]});
      axi_wr(REG_PAGE, {19'h0, page});
      chk("page write resp", 32'(RESP_OKAY), 32'(r));
      axi_rd(REG_PAGE);
      chk("page reg", 32'(page), d);
      axi_rd(REG_CFG);
      chk("cfg reg", 32'(i[2]), d);
      n0 = starts;
      link_cmd(op);
      chk("frame opcode", 32'(op), 32'(siBits[31:24]));
      chk("frame page", 32'(page), 32'(i[2] ? siBits[21:9] : siBits[22:10]));
      k = 0;
      while (starts == n0 && k < 40) begin
        @(posedge clk_sys);
        k++;
      end
      chk("start count", n0 + 1, starts);
      chk("rewrite kind", 32'(op[3]), 32'(rwSeen));
      chk("page index", 32'(page), 32'(capPage));
      chk("buffer", 32'(op[0]), 32'(capBuf));
      while (busyOut !== 1'b0 && k < 400) begin
        @(posedge clk_sys);
        k++;
      end
      chk_max("busy length", op[3] ? RW_N + 1 : CMP_N + 1, busyCnt);
      chk_max("busy short", -(op[3] ? RW_N : CMP_N), -busyCnt);
      if (!op[3]) lastMis = mis;
      check_status(exp_stat(1'b1, lastMis));
    end
    @(posedge clk_sys);
    extBusy <= 1'b1;
    check_status(exp_stat(1'b0, lastMis));
    n0 = starts;
    link_cmd(OP_CMP_BUF1);
    repeat (40) @(posedge clk_sys);
    chk("start while busy", n0, starts);
    extBusy <= 1'b0;
    link_cmd(OP_SLEEP);
    wait_sleep(1'b1);
    chk("asleep", 1, 32'(asleep));
    chk_max("sleep entry", 16, k);
    n0 = starts;
    link_cmd(OP_CMP_BUF2);
    repeat (40) @(posedge clk_sys);
    chk("start asleep", n0, starts);
    check_status(8'hff);
    link_cmd(OP_WAKE);
    wait_sleep(1'b0);
    chk("awake", 0, 32'(asleep));
    check_status(exp_stat(1'b1, lastMis));
    link_cmd(OP_SLEEP);
    wait_sleep(1'b1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk("asleep after reset", 0, 32'(asleep));
    check_status(exp_stat(1'b1, 1'b0));
    wrap_up();
  end
endmodule
